// File: core/sbr_cmd.v
// Sample buffer storage and remote query responder
// Operation
// RULE1 - Pause stops adding samples, keeps buffer; ignored when paused or reset
// RULE2 - Clear accepted in any storage state, aborts storage, erases points
// RULE3 - Output query returns X, Y, magnitude or phase for selector 1 to 4
// RULE4 - Display query returns display one or two value for selector 1 or 2
// RULE5 - Snapshot carries two to six selectors; all values latched together
// RULE6 - Snapshot codes 1..11 map X,Y,mag,phase,aux1-4,frequency,display one,two
// RULE7 - Snapshot answer lists values in request order separated by commas
// RULE8 - X,Y together and magnitude,phase together; pairs may be 10 us apart
// RULE9 - Aux values skew up to 32 us; frequency refreshed slowly
// RULE10 - Aux query takes selector 1 to 4, returns that input's voltage
// RULE11 - Point count answered any time, same for both channels, zero after clear
// RULE12 - Positions run from 0 oldest to N-1 newest
// RULE13 - ASCII trace sends each point then comma, terminator after last
// RULE14 - Trace needs channel 1 or 2, count at least one, start+count within N
// RULE15 - IEEE trace sends four-byte floats, no delimiters, four bytes per point
// RULE16 - No-command-pending bit stays clear until the last byte is sent
// RULE17 - Final byte of a binary transfer carries end-of-message flag
// RULE18 - Serial host uses eight-bit words and takes every byte raw
// RULE19 - Binary bytes go back to back; host must always be ready; here the output idles two cycles between points while the next is fetched
// RULE20 - Packed point: LSB first, 16-bit signed mantissa, exponent, zero byte
// RULE21 - Packed exponent ranges 0 to 248, top byte always zero
// RULE22 - In wrap mode host pauses storage before reading points
// RULE23 - Begin starts or resumes sampling, ignored while already running
// RULE24 - Up to 16383 points per channel; when wrapped oldest at 0, newest 16382
// RULE25 - Command-in-progress kept in bit 1 of serial poll status byte
// RULE26 - Point count and write position update together on every stored sample; count holds at DEPTH once full, position still advances
`timescale 1ns/100ps
`include "sbr_regs.vh"
module sbr_cmd #(
   parameter AW = 14,
   parameter [AW:0] DEPTH = `SBR_DEPTH
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire cmd_valid_in,
   output wire cmd_ready_out,
   input wire [3:0] cmd_code_in,
   input wire [2:0] cmd_nsel_in,
   input wire [23:0] cmd_sels_in,
   input wire [AW-1:0] cmd_start_in,
   input wire [AW:0] cmd_count_in,
   input wire [351:0] live_vals_in,
   input wire smp_valid_in,
   input wire [31:0] smp_ch1_in,
   input wire [31:0] smp_ch2_in,
   input wire loop_mode_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [7:0] out_data_out,
   output wire out_last_out,
   output reg err_out,
   output reg storing_out,
   output reg [AW:0] stored_count_out,
   output wire no_command_pending_bit_out,
   output wire [7:0] status_byte_out
);
   localparam S_IDLE = 5'h01;
   localparam S_FETCH = 5'h02;
   localparam S_WAIT = 5'h04;
   localparam S_EMIT = 5'h08;
   localparam S_TAIL = 5'h10;

   reg [31:0] mem1 [0:DEPTH-1];
   reg [31:0] mem2 [0:DEPTH-1];
   reg [31:0] q1_ff;
   reg [31:0] q2_ff;
   reg [AW-1:0] wr_ptr_ff;
   reg [4:0] state_ff;
   reg busy_ff;
   reg [1:0] fmt_ff;
   reg trace_ff;
   reg ch2_ff;
   reg [AW:0] items_ff;
   reg [AW-1:0] pos_ff;
   reg [23:0] sels_ff;
   reg [351:0] coherent_snapshot_query_ff;
   reg [31:0] word_ff;
   reg [3:0] bidx_ff;
   reg [8:0] buf_ff [0:1];
   reg bw_ff;
   reg br_ff;
   reg [1:0] bcnt_ff;

   reg bad;
   reg [2:0] n_load;
   reg [23:0] sels_load;
   reg [1:0] fmt_load;
   reg trace_load;
   reg [7:0] byte_w;
   reg blast_w;
   integer i;

   function [7:0] hex_chr;
      input [3:0] nib;
      begin
         hex_chr = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h57 + {4'h0, nib});
      end
   endfunction

   // Packed mantissa/exponent to single precision; zero mantissa gives +0
   function [31:0] to_ieee;
      input [31:0] p;
      reg [15:0] a;
      reg [4:0] k;
      reg [8:0] ex;
      reg [22:0] fr;
      integer j;
      begin
         a = p[15] ? (~p[15:0] + 16'h1) : p[15:0];
         k = 5'h0;
         for (j = 0; j < 16; j = j + 1) begin
            if (a[j])
               k = j[4:0];
         end
         ex = {1'b0, p[23:16]} + {4'h0, k} + `SBR_IEEE_BIAS - `SBR_EXP_BIAS;
         fr = {7'h0, a} << (5'd23 - k);
         to_ieee = (a == 16'h0) ? 32'h0 : {p[15], ex[7:0], fr};
      end
   endfunction

   wire is_store_cmd = (cmd_code_in == `SBR_CMD_PAUSE) || (cmd_code_in == `SBR_CMD_CLEAR) ||
      (cmd_code_in == `SBR_CMD_BEGIN);
   // Storage control stays reachable while a long readout drains
   assign cmd_ready_out = is_store_cmd | ~busy_ff;  // [RULE2]
   wire acc = cmd_valid_in & cmd_ready_out & ce_in;
   wire [3:0] s0 = cmd_sels_in[3:0];
   wire [AW+1:0] span = {1'b0, cmd_start_in} + {1'b0, cmd_count_in};
   wire full_w = (stored_count_out == DEPTH);

   // Once wrapped the oldest point sits at the write position
   wire [AW:0] abase = full_w ? {1'b0, wr_ptr_ff} : {(AW + 1){1'b0}};  // [RULE24]
   wire [AW:0] asum = abase + {1'b0, pos_ff};
   wire [AW:0] awrap = (asum >= DEPTH) ? (asum - DEPTH) : asum;  // [RULE12]

   wire [3:0] code = sels_ff[3:0];
   wire [8:0] sbase = {code - 4'h1, 5'h00};
   wire [31:0] live_word = (code == `SBR_SEL_COUNT) ?
      {{(31 - AW){1'b0}}, stored_count_out} : coherent_snapshot_query_ff[sbase +: 32];  // [RULE6] [RULE11]
   wire [31:0] q_w = ch2_ff ? q2_ff : q1_ff;
   wire last_item = (items_ff == {{AW{1'b0}}, 1'b1});

   always @* begin
      bad = 1'b0;
      n_load = 3'h1;
      sels_load = {20'h0, s0};
      fmt_load = `SBR_FMT_ASCII;
      trace_load = 1'b0;
      case (cmd_code_in)
         `SBR_CMD_PAUSE, `SBR_CMD_CLEAR, `SBR_CMD_BEGIN: begin
            bad = 1'b0;
         end
         `SBR_CMD_OUTV: begin
            bad = (s0 < `SBR_SEL_X) || (s0 > `SBR_SEL_PHASE);  // [RULE3]
         end
         `SBR_CMD_DISP: begin
            bad = (s0 < 4'h1) || (s0 > 4'h2);  // [RULE4]
            sels_load[3:0] = s0 + `SBR_SEL_DISP_BASE;
         end
         `SBR_CMD_AUX: begin
            bad = (s0 < 4'h1) || (s0 > 4'h4);  // [RULE10]
            sels_load[3:0] = s0 + `SBR_SEL_AUX_BASE;
         end
         `SBR_CMD_COUNT: begin
            sels_load[3:0] = `SBR_SEL_COUNT;  // [RULE11]
         end
         `SBR_CMD_COHERENT_SNAPSHOT_QUERY: begin
            n_load = cmd_nsel_in;
            sels_load = cmd_sels_in;
            bad = (cmd_nsel_in < `SBR_COHERENT_SNAPSHOT_QUERY_MIN) || (cmd_nsel_in > `SBR_COHERENT_SNAPSHOT_QUERY_MAX);  // [RULE5]
            for (i = 0; i < 6; i = i + 1) begin
               if ((i < cmd_nsel_in) && ((cmd_sels_in[4*i +: 4] == 4'h0) ||
                  (cmd_sels_in[4*i +: 4] > `SBR_SEL_LAST)))
                  bad = 1'b1;
            end
         end
         `SBR_CMD_TR_ASCII, `SBR_CMD_TR_IEEE, `SBR_CMD_TR_PACKED: begin
            trace_load = 1'b1;
            fmt_load = (cmd_code_in == `SBR_CMD_TR_IEEE) ? `SBR_FMT_IEEE :
               (cmd_code_in == `SBR_CMD_TR_PACKED) ? `SBR_FMT_PACKED : `SBR_FMT_ASCII;
            bad = (s0 < 4'h1) || (s0 > 4'h2) || (cmd_count_in == {(AW + 1){1'b0}}) ||
               (span > {1'b0, stored_count_out});  // [RULE14]
         end
         default: begin
            bad = 1'b1;
         end
      endcase
   end

   // Byte generator for the current item
   always @* begin
      byte_w = `SBR_CHR_TERM;
      blast_w = 1'b1;
      if (state_ff == S_EMIT) begin
         if (fmt_ff == `SBR_FMT_ASCII) begin
            if (bidx_ff < 4'h8) begin
               byte_w = hex_chr(word_ff[31:28]);
               blast_w = 1'b0;
            end else begin
               // Trace points always end in a comma, the terminator follows
               byte_w = (trace_ff | ~last_item) ? `SBR_CHR_COMMA : `SBR_CHR_TERM;  // [RULE7]
               blast_w = ~trace_ff & last_item;  // [RULE13]
            end
         end else begin
            byte_w = word_ff[7:0];  // [RULE20]
            blast_w = (bidx_ff == `SBR_BIN_BYTES - 4'h1) & last_item;  // [RULE17]
         end
      end
   end

   wire buf_full = (bcnt_ff == 2'h2);
   wire push = ((state_ff == S_EMIT) || (state_ff == S_TAIL)) & ~buf_full & ce_in;  // [RULE19]
   wire pop = out_valid_out & out_ready_in & ce_in;
   wire [8:0] head = buf_ff[br_ff];
   wire [3:0] nbytes = (fmt_ff == `SBR_FMT_ASCII) ? `SBR_ASCII_BYTES : `SBR_BIN_BYTES;
   wire item_done = push & (state_ff == S_EMIT) & (bidx_ff == nbytes - 4'h1);

   assign out_valid_out = (bcnt_ff != 2'h0);
   assign out_data_out = head[7:0];
   assign out_last_out = head[8];
   assign no_command_pending_bit_out = ~busy_ff;  // [RULE16]
   assign status_byte_out = busy_ff ? `SBR_SPOLL_BUSY : 8'h00;  // [RULE25]

   // Two-entry output buffer; a stalled receiver only stalls the generator
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         buf_ff[0] <= 9'h000;
         buf_ff[1] <= 9'h000;
         bw_ff <= 1'b0;
         br_ff <= 1'b0;
         bcnt_ff <= 2'h0;
      end else if (ce_in) begin
         if (push) begin
            buf_ff[bw_ff] <= {blast_w, byte_w};
            bw_ff <= ~bw_ff;
         end
         if (pop)
            br_ff <= ~br_ff;
         if (push & ~pop)
            bcnt_ff <= bcnt_ff + 2'h1;
         else if (pop & ~push)
            bcnt_ff <= bcnt_ff - 2'h1;
      end
   end

   // Sample memory, no reset: clearing drops the count instead
   always @(posedge clk_in) begin
      if (ce_in) begin
         if (storing_out & smp_valid_in) begin
            mem1[wr_ptr_ff] <= smp_ch1_in;
            mem2[wr_ptr_ff] <= smp_ch2_in;
         end
         q1_ff <= mem1[awrap[AW-1:0]];  // [RULE12]
         q2_ff <= mem2[awrap[AW-1:0]];
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         storing_out <= 1'b0;
         stored_count_out <= {(AW + 1){1'b0}};
         wr_ptr_ff <= {AW{1'b0}};
         err_out <= 1'b0;
      end else if (ce_in) begin
         err_out <= acc & bad;  // [RULE14]
         if (acc && (cmd_code_in == `SBR_CMD_CLEAR)) begin
            storing_out <= 1'b0;  // [RULE2]
            stored_count_out <= {(AW + 1){1'b0}};
            wr_ptr_ff <= {AW{1'b0}};
         end else begin
            if (storing_out & smp_valid_in) begin
               wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  wr_ptr_ff + 1'b1;  // [RULE26]
               if (!full_w)
                  stored_count_out <= stored_count_out + 1'b1;  // [RULE26] [RULE24]
               // One-shot ends after the last free position fills
               if (!loop_mode_in && (stored_count_out == DEPTH - 1'b1))
                  storing_out <= 1'b0;
            end
            if (acc && (cmd_code_in == `SBR_CMD_PAUSE))
               storing_out <= 1'b0;  // [RULE1]
            else if (acc && (cmd_code_in == `SBR_CMD_BEGIN) && !storing_out &&
               !(full_w && !loop_mode_in))
               storing_out <= 1'b1;  // [RULE23]
         end
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= S_IDLE;
         busy_ff <= 1'b0;
         fmt_ff <= `SBR_FMT_ASCII;
         trace_ff <= 1'b0;
         ch2_ff <= 1'b0;
         items_ff <= {(AW + 1){1'b0}};
         pos_ff <= {AW{1'b0}};
         sels_ff <= 24'h0;
         coherent_snapshot_query_ff <= 352'h0;
         word_ff <= 32'h0;
         bidx_ff <= 4'h0;
      end else if (ce_in) begin
         if (pop & out_last_out)
            busy_ff <= 1'b0;  // [RULE16]
         if (acc & ~bad & ~is_store_cmd) begin
            busy_ff <= 1'b1;
            state_ff <= S_FETCH;
            fmt_ff <= fmt_load;
            trace_ff <= trace_load;
            ch2_ff <= (s0 == 4'h2);
            items_ff <= trace_load ? cmd_count_in : {{(AW - 2){1'b0}}, n_load};
            pos_ff <= cmd_start_in;
            sels_ff <= sels_load;
            // Every live value is caught in the same cycle
            coherent_snapshot_query_ff <= live_vals_in;  // [RULE5] [RULE8] [RULE9]
         end
         case (state_ff)
            S_IDLE: begin
               bidx_ff <= 4'h0;
            end
            S_FETCH: begin
               state_ff <= S_WAIT;
            end
            S_WAIT: begin
               state_ff <= S_EMIT;
            end
            S_EMIT: begin
               if (push) begin
                  bidx_ff <= bidx_ff + 4'h1;
                  word_ff <= (fmt_ff == `SBR_FMT_ASCII) ? {word_ff[27:0], 4'h0} :
                     {8'h00, word_ff[31:8]};  // [RULE15] [RULE20]
               end
               if (item_done) begin
                  bidx_ff <= 4'h0;
                  items_ff <= items_ff - 1'b1;
                  pos_ff <= pos_ff + 1'b1;
                  sels_ff <= {4'h0, sels_ff[23:4]};  // [RULE7]
                  if (last_item)
                     state_ff <= (trace_ff && (fmt_ff == `SBR_FMT_ASCII)) ? S_TAIL : S_IDLE;
                  else
                     state_ff <= S_FETCH;
               end
            end
            S_TAIL: begin
               if (push)
                  state_ff <= S_IDLE;  // [RULE13]
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
         if (state_ff == S_WAIT) begin
            state_ff <= S_EMIT;
            if (!trace_ff)
               word_ff <= live_word;  // [RULE3] [RULE4] [RULE10]
            else if (fmt_ff == `SBR_FMT_PACKED)
               word_ff <= {8'h00, q_w[23:0]};  // [RULE21]
            else
               word_ff <= to_ieee(q_w);  // [RULE15]
         end
      end
   end
endmodule // sbr_cmd

// File: dv/sbr_cmd_props.sv
// Concurrent checks on the sample buffer command block ports
`timescale 1ns/100ps
`include "sbr_regs.vh"
module sbr_cmd_props #(parameter AW = 14, parameter [AW:0] DEPTH = `SBR_DEPTH) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire cmd_valid_in,
   input wire cmd_ready_out,
   input wire [3:0] cmd_code_in,
   input wire smp_valid_in,
   input wire loop_mode_in,
   input wire out_valid_out,
   input wire out_ready_in,
   input wire [7:0] out_data_out,
   input wire out_last_out,
   input wire storing_out,
   input wire [AW:0] stored_count_out,
   input wire no_command_pending_bit_out,
   input wire [7:0] status_byte_out
);
   wire acc = cmd_valid_in && cmd_ready_out && ce_in;
   wire pl = out_valid_out && out_ready_in && out_last_out && ce_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_stat; status_byte_out == {6'h00, !no_command_pending_bit_out, 1'b0}; endproperty
   a_stat: assert property (p_stat) else $error("status byte");
   property p_clr; acc && cmd_code_in == `SBR_CMD_CLEAR |=> stored_count_out == 0 && !storing_out;
   endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_pau;
      acc && cmd_code_in == `SBR_CMD_PAUSE && !smp_valid_in
      |=> !storing_out && $stable(stored_count_out);
   endproperty
   a_pau: assert property (p_pau) else $error("pause");
   property p_beg; acc && cmd_code_in == `SBR_CMD_BEGIN && !smp_valid_in
      && (loop_mode_in || stored_count_out != DEPTH) |=> storing_out; endproperty
   a_beg: assert property (p_beg) else $error("begin");
   property p_inc; storing_out && smp_valid_in && ce_in && !cmd_valid_in
      && stored_count_out < DEPTH |=> stored_count_out == $past(stored_count_out) + 1'b1;
   endproperty
   a_inc: assert property (p_inc) else $error("count step");
   property p_hold; ce_in && !smp_valid_in && !(acc && cmd_code_in == `SBR_CMD_CLEAR)
      |=> $stable(stored_count_out); endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   property p_bend; pl |-> ##[1:2] no_command_pending_bit_out; endproperty
   a_bend: assert property (p_bend) else $error("busy stuck");
   property p_bhold; !no_command_pending_bit_out && !pl && !$past(pl)
      |=> !no_command_pending_bit_out;
   endproperty
   a_bhold: assert property (p_bhold) else $error("busy early");
   property p_ans; acc && cmd_code_in == `SBR_CMD_COUNT |-> ##[3:5] out_valid_out; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_oh; out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out)
      && $stable(out_last_out); endproperty
   a_oh: assert property (p_oh) else $error("byte lost");
   cover property (acc && cmd_code_in == `SBR_CMD_TR_PACKED);
   cover property (out_valid_out && !out_ready_in);
   cover property (stored_count_out == DEPTH);
endmodule // sbr_cmd_props
bind sbr_cmd sbr_cmd_props #(.AW(AW), .DEPTH(DEPTH)) chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .ce_in(ce_in), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
   .cmd_code_in(cmd_code_in), .smp_valid_in(smp_valid_in), .loop_mode_in(loop_mode_in),
   .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_data_out(out_data_out),
   .out_last_out(out_last_out), .storing_out(storing_out), .stored_count_out(stored_count_out),
   .no_command_pending_bit_out(no_command_pending_bit_out), .status_byte_out(status_byte_out));

// File: dv/sbr_host_model.sv
// Host side receiver that takes response bytes, optionally stalling
`timescale 1ns/100ps
module sbr_host_model (
   input wire clk_in,
   input wire rst_n_in,
   input wire out_valid_in,
   input wire [7:0] out_data_in,
   input wire out_last_in,
   input wire stall_in,
   output reg out_ready_out
);
   reg [8:0] rx_q[$];
   reg [31:0] r;
   integer seed = 9;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out_ready_out <= 1'b0;
      end else begin
         // Raw bytes, end marked only by the final flag
         if (out_valid_in && out_ready_out) rx_q.push_back({out_last_in, out_data_in});
         r = $random(seed);
         out_ready_out <= stall_in ? r[0] : 1'b1;
      end
   end
endmodule // sbr_host_model

// File: dv/test_sbr_cmd.sv
// Self-checking bench for the sample buffer command block
`timescale 1ns/100ps
`include "sbr_regs.vh"
module test_sbr_cmd;
   reg clk_in = 0, rst_n_in = 0, ce_in = 1, cmd_valid_in = 0, smp_valid_in = 0;
   reg loop_mode_in = 0, stall = 0, st = 0;
   reg [3:0] cmd_code_in = 4'h0, cmd_start_in = 4'h0;
   reg [2:0] cmd_nsel_in = 3'h0;
   reg [23:0] cmd_sels_in = 24'h0, s;
   reg [4:0] cmd_count_in = 5'h0;
   reg [351:0] live_vals_in = 0;
   reg [31:0] smp_ch1_in = 32'h0, smp_ch2_in = 32'h0;
   wire cmd_ready_out, out_valid_out, out_ready_in, out_last_out, err_out, storing_out, ncp;
   wire [7:0] out_data_out, status_byte_out;
   wire [4:0] stored_count_out;
   integer n_fail = 0, checks = 0, seed = 5, n_err = 0, i, j, v;
   reg [31:0] q1[$], q2[$];
   reg [8:0] exp_q[$];
   always #4 clk_in = ~clk_in;
   always @(posedge clk_in) if (err_out === 1'b1) n_err = n_err + 1;
   sbr_cmd #(.AW(4), .DEPTH(5'h0f)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_code_in(cmd_code_in),
      .cmd_nsel_in(cmd_nsel_in), .cmd_sels_in(cmd_sels_in), .cmd_start_in(cmd_start_in),
      .cmd_count_in(cmd_count_in), .live_vals_in(live_vals_in), .smp_valid_in(smp_valid_in),
      .smp_ch1_in(smp_ch1_in), .smp_ch2_in(smp_ch2_in), .loop_mode_in(loop_mode_in),
      .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_data_out(out_data_out),
      .out_last_out(out_last_out), .err_out(err_out), .storing_out(storing_out),
      .stored_count_out(stored_count_out), .no_command_pending_bit_out(ncp),
      .status_byte_out(status_byte_out));
   sbr_host_model host_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .out_valid_in(out_valid_out),
      .out_data_in(out_data_out), .out_last_in(out_last_out), .stall_in(stall),
      .out_ready_out(out_ready_in));
   task results;
      begin
         $display("checks=%0d n_fail=%0d", checks, n_fail);
         if (n_fail == 0 && checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task fail(input [8*16:1] m);
      begin n_fail = n_fail + 1; $display("[FAIL] %0t %0s", $time, m); end
   endtask
   task chk(input [31:0] got, input [31:0] exp, input [8*16:1] m);
      begin checks = checks + 1; if (got !== exp) fail(m); end
   endtask
   function [31:0] lv(input integer c); lv = live_vals_in[32*(c-1) +: 32]; endfunction
   function [7:0] hx(input [3:0] n); hx = n < 4'ha ? 8'h30 + n : 8'h57 + n; endfunction
   // Packed point m * 2^(e-124) as a single float; exact, no rounding
   function [31:0] ieee(input [31:0] w);
      reg [16:0] m;
      reg [31:0] f;
      integer p;
      begin
         m = w[15] ? ~{1'b1, w[15:0]} + 17'h1 : {1'b0, w[15:0]};
         p = 16;
         while (p > 0 && !m[p]) p = p - 1;
         f = {15'h0, m} << (23 - p);
         ieee = m == 0 ? 32'h0 : {w[15], 8'(w[23:16] + p + 3), f[22:0]};
      end
   endfunction
   task ph(input [31:0] w, input [7:0] sep);
      integer k;
      begin
         for (k = 7; k >= 0; k--) exp_q.push_back({1'b0, hx(w[4*k +: 4])});
         exp_q.push_back({sep == `SBR_CHR_TERM, sep});
      end
   endtask
   task pb(input [31:0] w, input l);
      integer k;
      for (k = 0; k < 4; k++) exp_q.push_back({l && k == 3, w[8*k +: 8]});
   endtask
   task send(input [3:0] c, input [2:0] n, input [23:0] sl, input [3:0] a, input [4:0] k);
      integer t;
      begin
         @(posedge clk_in);
         cmd_code_in <= c;
         cmd_nsel_in <= n;
         cmd_sels_in <= sl;
         cmd_start_in <= a;
         cmd_count_in <= k;
         cmd_valid_in <= 1'b1;
         t = 0;
         @(negedge clk_in);
         while (cmd_ready_out !== 1'b1 && t < 100) begin @(negedge clk_in); t = t + 1; end
         if (t == 100) begin fail("ready timeout"); results; end
         @(posedge clk_in);
         cmd_valid_in <= 1'b0;
      end
   endtask
   task sc(input [3:0] c);
      begin send(c, 3'h0, 24'h0, 4'h0, 5'h0); repeat (2) @(posedge clk_in); end
   endtask
   task q(input [3:0] c, input [2:0] n, input [23:0] sl, input [3:0] a, input [4:0] k);
      integer t;
      begin
         send(c, n, sl, a, k);
         @(negedge clk_in);
         chk(ncp, 0, "not busy");
         t = 0;
         while (!(host_u.rx_q.size() > 0 && host_u.rx_q[host_u.rx_q.size()-1][8]) &&
            t < 3000) begin
            @(negedge clk_in);
            t = t + 1;
         end
         if (t == 3000) begin fail("resp timeout"); results; end
         chk(host_u.rx_q.size(), exp_q.size(), "resp length");
         if (host_u.rx_q.size() == exp_q.size())
            for (t = 0; t < exp_q.size(); t++) chk(host_u.rx_q[t], exp_q[t], "resp byte");
         host_u.rx_q.delete();
         exp_q.delete();
      end
   endtask
   task tr(input [3:0] c, input [3:0] ch, input [3:0] a, input [4:0] k);
      integer p;
      reg [31:0] w;
      begin
         for (p = a; p < a + k; p++) begin
            w = ch == 4'h1 ? q1[p] : q2[p];
            if (c == `SBR_CMD_TR_ASCII) ph(ieee(w), `SBR_CHR_COMMA);
            else if (c == `SBR_CMD_TR_IEEE) pb(ieee(w), p == a + k - 1);
            else pb({8'h00, w[23:0]}, p == a + k - 1);
         end
         if (c == `SBR_CMD_TR_ASCII) exp_q.push_back({1'b1, `SBR_CHR_TERM});
         q(c, 3'h0, {20'h0, ch}, a, k);
      end
   endtask
   task er(input [3:0] c, input [3:0] ch, input [3:0] a, input [4:0] k);
      integer n0;
      begin
         n0 = n_err;
         send(c, 3'h0, {20'h0, ch}, a, k);
         repeat (4) @(posedge clk_in);
         chk(n_err - n0, 1, "no error");
         chk(host_u.rx_q.size(), 0, "bytes on error");
      end
   endtask
   task smp(input integer n);
      integer k;
      reg [31:0] a, b;
      for (k = 0; k < n; k++) begin
         a = {8'h00, 8'($unsigned($random(seed)) % 200), 16'($random(seed))};
         b = {8'h00, 8'($unsigned($random(seed)) % 200), 16'($random(seed))};
         @(posedge clk_in);
         smp_valid_in <= 1'b1;
         smp_ch1_in <= a;
         smp_ch2_in <= b;
         if (st) begin
            q1.push_back(a);
            q2.push_back(b);
            if (q1.size() > 15) begin void'(q1.pop_front()); void'(q2.pop_front()); end
            if (!loop_mode_in && q1.size() == 15) st = 0;
         end
         @(posedge clk_in);
         smp_valid_in <= 1'b0;
         // Count is read after the storing edge has settled
         @(negedge clk_in);
      end
   endtask
   initial begin
      for (i = 0; i < 11; i++) live_vals_in[32*i +: 32] = $random(seed);
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(negedge clk_in);
      chk(stored_count_out, 0, "count at reset");
      chk(status_byte_out, 0, "status at reset");
      sc(`SBR_CMD_BEGIN); st = 1;
      smp(6);
      chk(stored_count_out, 6, "count");
      sc(`SBR_CMD_BEGIN);
      chk(storing_out, 1, "storing");
      sc(`SBR_CMD_PAUSE); st = 0;
      smp(2);
      sc(`SBR_CMD_PAUSE);
      chk(stored_count_out, 6, "paused count");
      ph(32'h6, `SBR_CHR_TERM); q(`SBR_CMD_COUNT, 3'h0, 24'h0, 4'h0, 5'h0);
      for (i = 1; i <= 4; i++) begin
         ph(lv(i), `SBR_CHR_TERM); q(`SBR_CMD_OUTV, 3'h0, 24'(i), 4'h0, 5'h0);
         ph(lv(4 + i), `SBR_CHR_TERM); q(`SBR_CMD_AUX, 3'h0, 24'(i), 4'h0, 5'h0);
         if (i < 3) begin
            ph(lv(9 + i), `SBR_CHR_TERM); q(`SBR_CMD_DISP, 3'h0, 24'(i), 4'h0, 5'h0);
         end
      end
      for (i = 2; i <= 6; i++) begin
         s = 24'h0;
         for (j = 0; j < i; j++) begin
            v = 1 + $unsigned($random(seed)) % 11;
            s[4*j +: 4] = 4'(v);
            ph(lv(v), j == i - 1 ? `SBR_CHR_TERM : `SBR_CHR_COMMA);
         end
         q(`SBR_CMD_COHERENT_SNAPSHOT_QUERY, 3'(i), s, 4'h0, 5'h0);
      end
      stall = 1;
      tr(`SBR_CMD_TR_PACKED, 4'h1, 4'h1, 5'h2);
      tr(`SBR_CMD_TR_IEEE, 4'h2, 4'h0, 5'h6);
      tr(`SBR_CMD_TR_ASCII, 4'h1, 4'h5, 5'h1);
      stall = 0;
      er(`SBR_CMD_TR_ASCII, 4'h1, 4'h0, 5'h0);
      er(`SBR_CMD_TR_IEEE, 4'h3, 4'h0, 5'h1);
      er(`SBR_CMD_TR_PACKED, 4'h2, 4'h3, 5'h4);
      er(4'hc, 4'h0, 4'h0, 5'h0);
      sc(`SBR_CMD_BEGIN); st = 1;
      smp(9);
      sc(`SBR_CMD_BEGIN);
      chk(stored_count_out, 15, "full count");
      chk(storing_out, 0, "one shot end");
      sc(`SBR_CMD_CLEAR); q1.delete(); q2.delete();
      chk(stored_count_out, 0, "cleared");
      ph(32'h0, `SBR_CHR_TERM); q(`SBR_CMD_COUNT, 3'h0, 24'h0, 4'h0, 5'h0);
      loop_mode_in <= 1'b1;
      sc(`SBR_CMD_BEGIN); st = 1;
      smp(18);
      sc(`SBR_CMD_PAUSE); st = 0;
      chk(stored_count_out, 15, "wrap count");
      tr(`SBR_CMD_TR_PACKED, 4'h2, 4'h0, 5'hf);
      sc(`SBR_CMD_BEGIN); st = 1;
      smp(1);
      // Clock enable low must freeze storage even against a clear
      ce_in <= 1'b0;
      sc(`SBR_CMD_CLEAR);
      chk(storing_out, 1, "ce freeze");
      ce_in <= 1'b1;
      sc(`SBR_CMD_CLEAR);
      chk(storing_out, 0, "clear running");
      results;
   end
endmodule // test_sbr_cmd

// File: inc/sbr_regs.vh
// Constants for the sample buffer readout command block
`ifndef SBR_REGS_VH
`define SBR_REGS_VH
`define SBR_CMD_PAUSE 4'h1
`define SBR_CMD_CLEAR 4'h2
`define SBR_CMD_BEGIN 4'h3
`define SBR_CMD_OUTV 4'h4
`define SBR_CMD_DISP 4'h5
`define SBR_CMD_COHERENT_SNAPSHOT_QUERY 4'h6
`define SBR_CMD_AUX 4'h7
`define SBR_CMD_COUNT 4'h8
`define SBR_CMD_TR_ASCII 4'h9
`define SBR_CMD_TR_IEEE 4'ha
`define SBR_CMD_TR_PACKED 4'hb
`define SBR_FMT_ASCII 2'h0
`define SBR_FMT_IEEE 2'h1
`define SBR_FMT_PACKED 2'h2
`define SBR_SEL_X 4'h1
`define SBR_SEL_PHASE 4'h4
`define SBR_SEL_AUX_BASE 4'h4
`define SBR_SEL_DISP_BASE 4'h9
`define SBR_SEL_LAST 4'hb
`define SBR_SEL_COUNT 4'hc
`define SBR_COHERENT_SNAPSHOT_QUERY_MIN 3'h2
`define SBR_COHERENT_SNAPSHOT_QUERY_MAX 3'h6
`define SBR_DEPTH 15'h3fff
`define SBR_EXP_BIAS 9'h07c
`define SBR_IEEE_BIAS 9'h07f
`define SBR_CHR_COMMA 8'h2c
`define SBR_CHR_TERM 8'h0a
`define SBR_SPOLL_BUSY 8'h02
`define SBR_ASCII_BYTES 4'h9
`define SBR_BIN_BYTES 4'h4
`endif
